// File: design/b4ds_device.sv
// SRAM end of the burst-of-four double-rate pin interface, with its own memory array.
// Assumes the input clocks and pins come from the controller on mclk and are resynchronised.
`timescale 1ns/1ns
module b4ds_device #(
  parameter int DATA_W = b4ds_pkg::DATA_W_X18,
  parameter int ADDR_W = b4ds_pkg::ADDR_W_X18,
  parameter int MEM_AW = ADDR_W
) (
  input wire logic mclk,
  input wire logic rst,
  b4ds_if.dev link,
  output logic termRangeHigh
);
  localparam int LANES = DATA_W / b4ds_pkg::BYTE_W;
  localparam int IDX_W = b4ds_pkg::BEAT_IDX_W;
  localparam int WORDS = b4ds_pkg::BURST_WORDS << MEM_AW;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic kPosM;
    logic kPosS;
    logic kPosD;
    logic kNegM;
    logic kNegS;
    logic kNegD;
    logic wpsM;
    logic wpsS;
    logic rpsM;
    logic rpsS;
    logic termM;
    logic termS;
    logic [LANES-1:0] bwsM;
    logic [LANES-1:0] bwsS;
    logic [ADDR_W-1:0] addrM;
    logic [ADDR_W-1:0] addrS;
    logic [DATA_W-1:0] dinM;
    logic [DATA_W-1:0] dinS;
    logic [ADDR_W-1:0] wrAddr;
    logic [ADDR_W-1:0] rdAddr;
    logic [2:0] wrLeft;
    logic [2:0] rdLeft;
    logic [2:0] initCnt;
    logic initDone;
    logic termHigh;
    logic [DATA_W-1:0] dout;
    logic doutOeN;
    logic valid;
    logic echo;
  } b4ds_dev_s;
  b4ds_dev_s s;
  b4ds_dev_s n;
  logic [DATA_W-1:0] mem [WORDS];
  logic posEdge;
  logic negEdge;
  logic anyEdge;
  logic memWe;
  logic [IDX_W-1:0] wrIdx;
  logic [IDX_W-1:0] rdIdx;
  logic [DATA_W-1:0] rdWord;
  // ----------------------------------------------------------------
  // Edge detection on the resynchronised input clocks
  // ----------------------------------------------------------------
  // Gated by initDone so a clock already high at reset release is no false edge
  assign posEdge = s.initDone && s.kPosS && !s.kPosD;
  assign negEdge = s.initDone && s.kNegS && !s.kNegD;
  assign anyEdge = posEdge || negEdge;
  // Burst words are sequential from word zero of the addressed location
  assign wrIdx = IDX_W'(b4ds_pkg::BURST_LEN - s.wrLeft);
  assign rdIdx = IDX_W'(b4ds_pkg::BURST_LEN - s.rdLeft);
  assign memWe = anyEdge && (s.wrLeft != b4ds_pkg::BEAT_NONE);
  assign rdWord = mem[{s.rdAddr[MEM_AW-1:0], rdIdx}];
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    // Two-flop synchronisers; only the second stage is read
    n.kPosM = link.kPos;
    n.kPosS = s.kPosM;
    n.kPosD = s.kPosS;
    n.kNegM = link.kNeg;
    n.kNegS = s.kNegM;
    n.kNegD = s.kNegS;
    n.wpsM = link.writePortSelectN;
    n.wpsS = s.wpsM;
    n.rpsM = link.readPortSelectN;
    n.rpsS = s.rpsM;
    n.termM = link.terminationRangeSelect;
    n.termS = s.termM;
    n.bwsM = link.byteWriteSelectN;
    n.bwsS = s.bwsM;
    n.addrM = link.addr;
    n.addrS = s.addrM;
    n.dinM = link.writeDataIn;
    n.dinS = s.dinM;
    // Termination range caught once, after the synchroniser has settled
    if (!s.initDone)
    begin
      n.initCnt = s.initCnt + b4ds_pkg::INIT_STEP;
      if (s.initCnt == b4ds_pkg::INIT_CYCLES)
      begin
        n.initDone = 1'b1;
        n.termHigh = s.termS;
      end
    end
    // Write beats: one word per clock rise after the command
    if (memWe)
      n.wrLeft = s.wrLeft - b4ds_pkg::BEAT_ONE;
    // Read wins if both selects are low on one edge: the single address belongs to it
    if (posEdge && !s.wpsS && s.rpsS && n.wrLeft == b4ds_pkg::BEAT_NONE)
    begin
      n.wrAddr = s.addrS;
      n.wrLeft = b4ds_pkg::BURST_LEN;
    end
    // Read beats launch on both clock rises; echo toggles on every rise
    if (anyEdge)
    begin
      n.echo = !s.echo;
      n.valid = 1'b0;
      if (s.rdLeft != b4ds_pkg::BEAT_NONE)
      begin
        n.dout = rdWord;
        n.valid = 1'b1;
        n.doutOeN = 1'b0;
        n.rdLeft = s.rdLeft - b4ds_pkg::BEAT_ONE;
      end
      else if (posEdge)
        n.doutOeN = 1'b1;
    end
    // A new read is taken only once the running burst has launched its last word
    if (posEdge && !s.rpsS && n.rdLeft == b4ds_pkg::BEAT_NONE)
    begin
      n.rdAddr = s.addrS;
      n.rdLeft = b4ds_pkg::BURST_LEN;
    end
  end
  // ----------------------------------------------------------------
  // Memory array with per-byte write gating
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (memWe)
      for (int l = 0; l < LANES; l++)
        if (!s.bwsS[l])
          mem[{s.wrAddr[MEM_AW-1:0], wrIdx}][l*b4ds_pkg::BYTE_W +: b4ds_pkg::BYTE_W] <=
            s.dinS[l*b4ds_pkg::BYTE_W +: b4ds_pkg::BYTE_W];
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Selects reset to deselected so the settling window starts nothing
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s <= '0;
      s.wpsM <= 1'b1;
      s.wpsS <= 1'b1;
      s.rpsM <= 1'b1;
      s.rpsS <= 1'b1;
      s.bwsM <= '1;
      s.bwsS <= '1;
      s.termHigh <= b4ds_pkg::TERM_RANGE_DEFAULT;
      s.doutOeN <= 1'b1;
    end
    else
      s <= n;
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.readDataOut = s.dout;
  assign link.readDataOeN = s.doutOeN;
  assign link.outputValidFlag = s.valid;
  assign link.echoClock = s.echo;
  assign termRangeHigh = s.termHigh;
endmodule

// File: design/b4ds_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module b4ds_fifo #(
  parameter int W = b4ds_pkg::DATA_W_X18,
  parameter int DEPTH = b4ds_pkg::FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [CW-1:0] count
);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] used;
  } b4ds_fifo_s;
  b4ds_fifo_s s;
  b4ds_fifo_s n;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;
  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign inReady = s.used != CW'(DEPTH);
  assign outValid = s.used != '0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[s.rdPtr];
  assign count = s.used;
  // Pointer wrap is explicit so DEPTH need not be a power of two
  always_comb
  begin
    n = s;
    if (push)
      n.wrPtr = (s.wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(s.wrPtr + 1'b1);
    if (pop)
      n.rdPtr = (s.rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(s.rdPtr + 1'b1);
    n.used = CW'(s.used + CW'(push) - CW'(pop));
  end
  // Storage has no reset; only the occupancy count defines emptiness
  always_ff @(posedge clk)
  begin
    if (push)
      mem[s.wrPtr] <= inData;
    if (rst)
      s <= '0;
    else
      s <= n;
  end
endmodule

// File: design/b4ds_host.sv
// Memory controller end: makes the input clocks, issues bursts and buffers read words.
// Assumes a user that offers one command at a time and drains read words from the FIFO.
`timescale 1ns/1ns
module b4ds_host #(
  parameter int DATA_W = b4ds_pkg::DATA_W_X18,
  parameter int ADDR_W = b4ds_pkg::ADDR_W_X18,
  parameter int DEPTH = b4ds_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  b4ds_if.host link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [b4ds_pkg::BURST_WORDS*DATA_W-1:0] cmdWrData,
  input wire logic [b4ds_pkg::BURST_WORDS*(DATA_W/b4ds_pkg::BYTE_W)-1:0] cmdWrByteN,
  input wire logic termSelHigh,
  output logic rdValid,
  input wire logic rdReady,
  output logic [DATA_W-1:0] rdData
);
  localparam int LANES = DATA_W / b4ds_pkg::BYTE_W;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int ROOM = DEPTH - b4ds_pkg::BURST_WORDS;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] phase;
    logic kPos;
    logic kNeg;
    logic wpsN;
    logic rpsN;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bwsN;
    logic [DATA_W-1:0] wdata;
    logic [b4ds_pkg::BURST_WORDS*DATA_W-1:0] wrBuf;
    logic [b4ds_pkg::BURST_WORDS*LANES-1:0] wrLanes;
    logic [2:0] wrLeft;
    logic [2:0] rdLeft;
    logic cmdReady;
    logic termOut;
    logic termOeN;
    logic [DATA_W-1:0] rdM;
    logic [DATA_W-1:0] rdS;
    logic vldM;
    logic vldS;
    logic echoM;
    logic echoS;
    logic echoD;
  } b4ds_host_s;
  b4ds_host_s s;
  b4ds_host_s n;
  logic capture;
  logic fifoInReady;
  logic [CW-1:0] fifoCount;
  logic room;
  // A word arrives when the echo toggles with the valid flag up
  assign capture = (s.echoS != s.echoD) && s.vldS && (s.rdLeft != b4ds_pkg::BEAT_NONE);
  // Room for a whole burst is reserved before a read is issued, so pushes never stall
  assign room = fifoInReady && (fifoCount <= CW'(ROOM));
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    // Divider: K high for phases 0 and 1, complement clock opposite
    n.phase = s.phase + b4ds_pkg::PH_STEP;
    n.kPos = (n.phase == b4ds_pkg::PH_KPOS_RISE) || (n.phase == b4ds_pkg::PH_BEAT_A);
    n.kNeg = !n.kPos;
    n.termOut = 1'b0;
    n.termOeN = termSelHigh;
    // Commands change one mclk after the complement rise; the SRAM only samples them on K rise
    n.cmdReady = (n.phase == b4ds_pkg::PH_KNEG_RISE) && (s.wrLeft == b4ds_pkg::BEAT_NONE)
      && (s.rdLeft == b4ds_pkg::BEAT_NONE) && room;
    if (s.phase == b4ds_pkg::PH_KNEG_RISE)
    begin
      n.wpsN = 1'b1;
      n.rpsN = 1'b1;
      if (s.cmdReady && cmdValid)
      begin
        n.cmdReady = 1'b0;
        n.addr = cmdAddr;
        n.wpsN = !cmdWrite;
        n.rpsN = cmdWrite;
        if (cmdWrite)
        begin
          n.wrBuf = cmdWrData;
          n.wrLanes = cmdWrByteN;
          n.wrLeft = b4ds_pkg::BURST_LEN;
        end
        else
          n.rdLeft = b4ds_pkg::BURST_LEN;
      end
    end
    // Beats change mid half-period so each is stable across its sampling rise;
    // keyed on the coming phase, since keying on the current one moves beats onto the rises
    if (n.phase == b4ds_pkg::PH_BEAT_A || n.phase == b4ds_pkg::PH_BEAT_B)
    begin
      if (s.wrLeft != b4ds_pkg::BEAT_NONE)
      begin
        n.wdata = s.wrBuf[DATA_W-1:0];
        n.bwsN = s.wrLanes[LANES-1:0];
        n.wrBuf = s.wrBuf >> DATA_W;
        n.wrLanes = s.wrLanes >> LANES;
        n.wrLeft = s.wrLeft - b4ds_pkg::BEAT_ONE;
      end
      else
        n.bwsN = '1;
    end
    // Read return path resynchronised before use
    n.rdM = link.readData;
    n.rdS = s.rdM;
    n.vldM = link.outputValidFlag;
    n.vldS = s.vldM;
    n.echoM = link.echoClock;
    n.echoS = s.echoM;
    n.echoD = s.echoS;
    if (capture)
      n.rdLeft = s.rdLeft - b4ds_pkg::BEAT_ONE;
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s <= '0;
      s.kNeg <= 1'b1;
      s.wpsN <= 1'b1;
      s.rpsN <= 1'b1;
      s.bwsN <= '1;
      s.termOeN <= 1'b1;
    end
    else
      s <= n;
  end
  // ----------------------------------------------------------------
  // Read word buffer
  // ----------------------------------------------------------------
  b4ds_fifo #(
    .W(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .inValid(capture),
    .inReady(fifoInReady),
    .inData(s.rdS),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData),
    .count(fifoCount)
  );
  assign link.kPos = s.kPos;
  assign link.kNeg = s.kNeg;
  assign link.writePortSelectN = s.wpsN;
  assign link.readPortSelectN = s.rpsN;
  assign link.addr = s.addr;
  assign link.byteWriteSelectN = s.bwsN;
  assign link.writeDataIn = s.wdata;
  assign link.termSelOut = s.termOut;
  assign link.termSelOeN = s.termOeN;
  assign cmdReady = s.cmdReady;
endmodule

// File: design/b4ds_if.sv
// Pin bundle between the SRAM end and the memory controller end.
// Assumes both ends run on the same mclk; the wire levels are resolved here.
`timescale 1ns/1ns
interface b4ds_if #(
  parameter int DATA_W = b4ds_pkg::DATA_W_X18,
  parameter int ADDR_W = b4ds_pkg::ADDR_W_X18
);
  localparam int LANES = DATA_W / b4ds_pkg::BYTE_W;
  logic kPos;
  logic kNeg;
  logic writePortSelectN;
  logic readPortSelectN;
  logic [LANES-1:0] byteWriteSelectN;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] writeDataIn;
  logic [DATA_W-1:0] readDataOut;
  logic readDataOeN;
  logic [DATA_W-1:0] readData;
  logic outputValidFlag;
  logic echoClock;
  logic termSelOut;
  logic termSelOeN;
  logic terminationRangeSelect;
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Released read bus reads all ones, as if pulled up; readDataOeN tells idle from data
  assign readData = readDataOeN ? '1 : readDataOut;
  // Termination select floats to the high range
  assign terminationRangeSelect = termSelOeN ? b4ds_pkg::TERM_RANGE_DEFAULT : termSelOut;
  modport dev (
    input kPos, kNeg, writePortSelectN, readPortSelectN, byteWriteSelectN, addr, writeDataIn,
    input terminationRangeSelect,
    output readDataOut, readDataOeN, outputValidFlag, echoClock
  );
  modport host (
    output kPos, kNeg, writePortSelectN, readPortSelectN, byteWriteSelectN, addr, writeDataIn,
    output termSelOut, termSelOeN,
    input readData, outputValidFlag, echoClock
  );
endinterface

// File: design/b4ds_pkg.sv
// Shared constants for the four-word burst double-rate SRAM pin interface.
// Assumes one system clock mclk; the SRAM input clocks are made from it by a divider.
package b4ds_pkg;
  // ----------------------------------------------------------------
  // Data and address widths per variant
  // ----------------------------------------------------------------
  localparam int BYTE_W = 9;
  localparam int DATA_W_X18 = 18;
  localparam int DATA_W_X36 = 36;
  localparam int ADDR_W_X18 = 18;
  localparam int ADDR_W_X36 = 19;
  // ----------------------------------------------------------------
  // Burst shape
  // ----------------------------------------------------------------
  localparam int BURST_WORDS = 4;
  localparam int BEAT_IDX_W = 2;
  localparam logic [2:0] BURST_LEN = 3'h4;
  localparam logic [2:0] BEAT_ONE = 3'h1;
  localparam logic [2:0] BEAT_NONE = 3'h0;
  // ----------------------------------------------------------------
  // Timing: input clock period built from the system clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int K_PERIOD_NS = 400;
  localparam int K_PHASES = K_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PH_KPOS_RISE = 2'h0;
  localparam logic [1:0] PH_BEAT_A = 2'h1;
  localparam logic [1:0] PH_KNEG_RISE = 2'h2;
  localparam logic [1:0] PH_BEAT_B = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;
  // ----------------------------------------------------------------
  // Power-up and buffering
  // ----------------------------------------------------------------
  localparam logic [2:0] INIT_CYCLES = 3'h3;
  localparam logic [2:0] INIT_STEP = 3'h1;
  localparam logic TERM_RANGE_DEFAULT = 1'h1;
  localparam int FIFO_DEPTH = 8;
endpackage

// File: tb/b4ds_link_asserts.sv
// Checker of the pin bundle between the SRAM end and the controller end.
// Assumes one mclk for both ends and a synchronous active-high rst.
`timescale 1ns/1ns
module b4ds_link_asserts #(
  parameter int DATA_W = b4ds_pkg::DATA_W_X18
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic kPos,
  input wire logic kNeg,
  input wire logic writePortSelectN,
  input wire logic readPortSelectN,
  input wire logic [DATA_W-1:0] readDataOut,
  input wire logic readDataOeN,
  input wire logic outputValidFlag,
  input wire logic echoClock
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Selects lead the K rise by one mclk
  sequence kRiseNext;
    ##1 $rose(kPos);
  endsequence
  // Four beats of two mclk each, then valid drops
  sequence validBurst;
    outputValidFlag [*8] ##1 !outputValidFlag;
  endsequence
  // One detected rise every two mclk
  sequence echoStep;
    ##1 !$changed(echoClock) ##1 $changed(echoClock);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  write_select_a: assert property ($fell(writePortSelectN) |-> kRiseNext)
    else $error("write select not seen at a K rise");
  read_select_a: assert property ($fell(readPortSelectN) |-> kRiseNext)
    else $error("read select not seen at a K rise");
  read_start_a: assert property ($rose(kPos) && !readPortSelectN |-> ##[1:6] outputValidFlag)
    else $error("read did not start after K rise");
  burst_four_a: assert property ($rose(outputValidFlag) |-> validBurst)
    else $error("read burst length wrong");
  bus_drive_a: assert property (outputValidFlag |-> !readDataOeN)
    else $error("valid beat without driven bus");
  bus_release_a: assert property ($fell(outputValidFlag) && readPortSelectN |-> ##[0:5] readDataOeN)
    else $error("read bus not released");
  valid_echo_a: assert property ($changed(outputValidFlag) |-> $changed(echoClock))
    else $error("valid not aligned with echo");
  word_hold_a: assert property (outputValidFlag && !$changed(echoClock) |-> $stable(readDataOut))
    else $error("read word changed between rises");
  echo_rate_a: assert property ($changed(echoClock) |-> echoStep)
    else $error("rise detection rate wrong");
  clock_pair_a: assert property (kNeg == !kPos)
    else $error("input clocks not complementary");
endmodule

// File: tb/tb_b4ds.sv
// Testbench joining the SRAM end and the controller end through the pin bundle.
// Assumes mclk at 10 MHz and the user ports of the controller driven here.
`timescale 1ns/1ns
module tb_b4ds;
  logic mclk;
  logic rst;
  logic cmdValid;
  logic cmdReady;
  logic cmdWrite;
  logic [17:0] cmdAddr;
  logic [71:0] cmdWrData;
  logic [7:0] cmdWrByteN;
  logic termSelHigh;
  logic rdValid;
  logic rdReady;
  logic [17:0] rdData;
  logic termRangeHigh;
  int n_mismatch;
  int n_compared;
  int cycles;
  localparam logic [71:0] DATA_A = {18'h0_7788, 18'h3_5566, 18'h1_1122, 18'h2_3344};
  localparam logic [71:0] DATA_B = {18'h1_0F0F, 18'h2_A5A5, 18'h0_3C3C, 18'h3_1234};
  localparam logic [71:0] DATA_C = {18'h2_0001, 18'h0_BEEF, 18'h3_0C0C, 18'h1_5A5A};
  // Lanes 8'h39 over A: w0 keeps low byte, w1 keeps high byte, w2 kept whole
  localparam logic [71:0] MERGED = {DATA_B[71:54], DATA_A[53:27], DATA_B[26:9], DATA_A[8:0]};
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  b4ds_if link ();
  // Small array keeps the run light; upper address bits are ignored
  b4ds_device #(.MEM_AW(6)) u_b4ds_device (.mclk(mclk), .rst(rst), .link(link), .termRangeHigh(termRangeHigh));
  b4ds_host u_b4ds_host (.mclk(mclk), .rst(rst), .link(link), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdWrByteN(cmdWrByteN),
    .termSelHigh(termSelHigh), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
  b4ds_link_asserts u_b4ds_link_asserts (.mclk(mclk), .rst(rst), .kPos(link.kPos), .kNeg(link.kNeg),
    .writePortSelectN(link.writePortSelectN), .readPortSelectN(link.readPortSelectN),
    .readDataOut(link.readDataOut), .readDataOeN(link.readDataOeN),
    .outputValidFlag(link.outputValidFlag), .echoClock(link.echoClock));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One edge first, so cmdValid is never set twice in one time step
  task automatic send_cmd(input logic wr, input logic [17:0] a, input logic [71:0] d, input logic [7:0] bn,
    input logic expTaken);
    logic taken;
    taken = 1'b0;
    @(posedge mclk);
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdWrData <= d;
    cmdWrByteN <= bn;
    cmdValid <= 1'b1;
    for (int i = 0; i < 40 && !taken; i++)
    begin
      @(posedge mclk);
      taken = cmdReady;
    end
    cmdValid <= 1'b0;
    chk({35'h0, taken}, {35'h0, expTaken});
  endtask
  // Bounded wait for a word; rdReady is held by the caller
  task automatic pop(input logic [17:0] exp);
    int i;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (rdValid !== 1'b1 && i < 60);
    chk({35'h0, rdValid}, 36'h1);
    chk({18'h0, rdData}, {18'h0, exp});
  endtask
  task automatic read_burst(input logic [17:0] a, input logic [71:0] exp);
    send_cmd(1'b0, a, 72'h0, 8'h00, 1'b1);
    rdReady <= 1'b1;
    for (int w = 0; w < 4; w++)
      pop(exp[18*w +: 18]);
    rdReady <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Termination is latched once; the idle read bus floats
  task automatic t_power_up();
    repeat (10) @(posedge mclk);
    chk({35'h0, termRangeHigh}, 36'h0);
    chk({35'h0, link.readDataOeN}, 36'h1);
    termSelHigh <= 1'b1;
    repeat (20) @(posedge mclk);
    chk({35'h0, link.terminationRangeSelect}, 36'h1);
    chk({35'h0, termRangeHigh}, 36'h0);
  endtask
  // Second reset with the pin left floating latches the high range; memory survives it
  task automatic t_reset_float();
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({35'h0, termRangeHigh}, 36'h1);
    read_burst(18'h0_0009, DATA_C);
  endtask
  task automatic t_full_burst();
    send_cmd(1'b1, 18'h0_0005, DATA_A, 8'h00, 1'b1);
    read_burst(18'h0_0005, DATA_A);
  endtask
  // Mixed lanes per beat, one beat fully masked
  task automatic t_byte_lanes();
    send_cmd(1'b1, 18'h0_0005, DATA_B, 8'h39, 1'b1);
    read_burst(18'h0_0005, MERGED);
  endtask
  // Fill the read buffer while stalled, see it refuse, then drain it
  task automatic t_fifo_fill();
    send_cmd(1'b1, 18'h0_0009, DATA_C, 8'h00, 1'b1);
    send_cmd(1'b0, 18'h0_0005, 72'h0, 8'h00, 1'b1);
    send_cmd(1'b0, 18'h0_0009, 72'h0, 8'h00, 1'b1);
    send_cmd(1'b0, 18'h0_0005, 72'h0, 8'h00, 1'b0);
    chk({35'h0, rdValid}, 36'h1);
    rdReady <= 1'b1;
    for (int w = 0; w < 8; w++)
      pop(w < 4 ? MERGED[18*w +: 18] : DATA_C[18*(w-4) +: 18]);
    rdReady <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({35'h0, rdValid}, 36'h0);
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Watchdog sized well above the few hundred cycles the run needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 18'h0;
    cmdWrData = 72'h0;
    cmdWrByteN = 8'hFF;
    termSelHigh = 1'b0;
    rdReady = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_power_up();
    t_full_burst();
    t_byte_lanes();
    t_fifo_fill();
    t_reset_float();
    complete_run();
  end
endmodule
